//--- design/power_state_pkg.sv
// shared types and constants for the regulator power state control
package power_state_pkg;

  // ref_clk rate and derived cycle counts
  localparam int CLK_KHZ = 25000;
  localparam int LONG_PRESS_MS = 4000;
  localparam int OC_FAULT_US = 8000;
  localparam int SETTLE_US = 3000;
  localparam int CNT_W = 27;
  localparam logic [CNT_W-1:0] LONG_PRESS_CYC =
    CNT_W'(CLK_KHZ * LONG_PRESS_MS);
  localparam logic [CNT_W-1:0] OC_FAULT_CYC =
    CNT_W'((CLK_KHZ * OC_FAULT_US) / 1000);
  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((CLK_KHZ * SETTLE_US + 999) / 1000);
  localparam logic [CNT_W-1:0] SEQ_SLOT_CYC = 27'h0000032;
  localparam logic [CNT_W-1:0] SS_STEP_CYC = 27'h0000019;
  localparam int NUM_REG = 4;

  // switch mode select codes
  localparam logic [3:0] SEL_OFF_OFF = 4'h0;
  localparam logic [3:0] SEL_PWM_OFF = 4'h1;
  localparam logic [3:0] SEL_PFM_OFF = 4'h3;
  localparam logic [3:0] SEL_APS_OFF = 4'h4;
  localparam logic [3:0] SEL_PWM_PWM = 4'h5;
  localparam logic [3:0] SEL_PWM_APS = 4'h6;
  localparam logic [3:0] SEL_APS_APS = 4'h8;
  localparam logic [3:0] SEL_APS_PFM = 4'hC;
  localparam logic [3:0] SEL_PWM_PFM = 4'hD;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_ON = 3'h1,
    ST_STANDBY = 3'h3,
    ST_SLEEP = 3'h2,
    ST_COIN = 3'h6
  } power_state_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_PFM = 2'h1,
    MODE_APS = 2'h2,
    MODE_PWM = 2'h3
  } switch_mode_t;

  typedef enum logic [1:0] {
    SS_PFM = 2'h0,
    SS_APS = 2'h1,
    SS_PWM = 2'h3,
    SS_DONE = 2'h2
  } soft_start_t;

  typedef struct packed {
    logic sleepKeep;
    logic [3:0] switchModeSelect;
    logic [6:0] normalSetpoint;
    logic [6:0] standbySetpoint;
  } reg_cfg_t;

  typedef struct packed {
    logic enable;
    logic discharge;
    switch_mode_t mode;
    logic [6:0] setpoint;
  } reg_out_t;

endpackage : power_state_pkg

//--- design/regulator_power_state_control.sv
// power state sequencer and buck regulator mode/set point control
// Summary of operation
// RQ1: style 0, keep 0, button low: power off
// RQ2: style 1, keep 0: off after 4 s
// RQ3: auto restart follows long-press power-off
// RQ4: thermal condition blocks turn-on, keeps off
// RQ5: stay off until over-temperature clears
// RQ6: thermal shutdown raises no interrupt
// RQ7: undervoltage moves to coin cell state
// RQ8: overcurrent over 8 ms raises fault
// RQ9: soft-start PULSE_FREQUENCY_MODE, AUTO_PULSE_SKIP_MODE, PWM, then programmed
// RQ10: decode switch mode select per table
// RQ11: off mode disables and discharges output
// RQ12: mode follows writes, standby, sleep, load
// RQ13: standby uses standby set point, mode
// RQ14: leaving standby restores normal settings
// RQ15: normal and standby share set point encoding
// RQ16: turn-off: keep 1 sleeps, keep 0 off
// RQ17: sleep uses sleep set point, PULSE_FREQUENCY_MODE
// RQ18: kept regulator goes straight to normal
// RQ19: off regulator re-sequenced at its slot
// RQ20: group one sleep set point is 6 bits
// RQ21: standby is pin xor invert, on only
// RQ22: partner asserts button to leave sleep
// RQ23: timers restart when condition goes inactive
`timescale 1ns/1ps
`default_nettype none
module regulator_power_state_control #(
  parameter int NUM_REG = power_state_pkg::NUM_REG,
  parameter logic [power_state_pkg::CNT_W-1:0] LONG_PRESS_CYC =
    power_state_pkg::LONG_PRESS_CYC,
  parameter logic [power_state_pkg::CNT_W-1:0] OC_FAULT_CYC =
    power_state_pkg::OC_FAULT_CYC,
  parameter logic [power_state_pkg::CNT_W-1:0] SETTLE_CYC =
    power_state_pkg::SETTLE_CYC,
  parameter logic [power_state_pkg::CNT_W-1:0] SEQ_SLOT_CYC =
    power_state_pkg::SEQ_SLOT_CYC,
  parameter logic [power_state_pkg::CNT_W-1:0] SS_STEP_CYC =
    power_state_pkg::SS_STEP_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic powerButtonInput,
  input wire logic standbyPin,
  input wire logic thermalShutdown,
  input wire logic inputUndervoltage,
  input wire logic [NUM_REG-1:0] overcurrent,
  input wire logic [NUM_REG-1:0] inRegulation,
  input wire logic buttonStyleSelect,
  input wire logic longPressOffEnable,
  input wire logic autoRestartEnable,
  input wire logic standbyPolarityInvert,
  input wire power_state_pkg::reg_cfg_t [NUM_REG-1:0] regCfg,
  input wire logic [5:0] group1SleepSetpoint,
  input wire logic [NUM_REG-2:0][6:0] otherSleepSetpoint,
  output power_state_pkg::reg_out_t [NUM_REG-1:0] regOut,
  output logic [NUM_REG-1:0] faultIrq,
  output power_state_pkg::power_state_t powerState
);
  import power_state_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic enable;
    soft_start_t phase;
    logic [CNT_W-1:0] ssCnt;
    logic [CNT_W-1:0] ocCnt;
  } reg_state_t;

  typedef struct packed {
    power_state_t state;
    logic btnS1;
    logic btnS2;
    logic btnPrev;
    logic stbyS1;
    logic stbyS2;
    logic thermS1;
    logic thermS2;
    logic uvS1;
    logic uvS2;
    logic [NUM_REG-1:0] ocS1;
    logic [NUM_REG-1:0] ocS2;
    logic [NUM_REG-1:0] regS1;
    logic [NUM_REG-1:0] regS2;
    logic restart;
    logic seqRun;
    logic [CNT_W-1:0] seqCnt;
    logic [CNT_W-1:0] lpCnt;
    reg_state_t [NUM_REG-1:0] regs;
    reg_out_t [NUM_REG-1:0] outs;
    logic [NUM_REG-1:0] fault;
  } state_t;

  state_t st;
  state_t next_st;
  logic offEvt;
  logic longEvt;
  logic turnOn;
  logic standbyCtl;
  logic allKeepOff;

  ////////////////////////////////////////////////////////////////////////////
  // mode select decode, normal or standby column
  function automatic switch_mode_t decodeMode(input logic [3:0] sel,
                                              input logic stby);
    switch_mode_t m;
    case (sel)
      SEL_PWM_OFF: m = stby ? MODE_OFF : MODE_PWM;
      SEL_PFM_OFF: m = stby ? MODE_OFF : MODE_PFM;
      SEL_APS_OFF: m = stby ? MODE_OFF : MODE_APS;
      SEL_PWM_PWM: m = MODE_PWM;
      SEL_PWM_APS: m = stby ? MODE_APS : MODE_PWM;
      SEL_APS_APS: m = MODE_APS;
      SEL_APS_PFM: m = stby ? MODE_PFM : MODE_APS;
      SEL_PWM_PFM: m = stby ? MODE_PFM : MODE_PWM;
      default: m = MODE_OFF; // reserved codes treated as off
    endcase
    return m; // RQ10
  endfunction : decodeMode

  function automatic logic [CNT_W-1:0] slotAt(input int i);
    return CNT_W'(SEQ_SLOT_CYC * (i + 1));
  endfunction : slotAt

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.btnS1 = powerButtonInput;
    next_st.btnS2 = st.btnS1;
    next_st.btnPrev = st.btnS2;
    next_st.stbyS1 = standbyPin;
    next_st.stbyS2 = st.stbyS1;
    next_st.thermS1 = thermalShutdown;
    next_st.thermS2 = st.thermS1;
    next_st.uvS1 = inputUndervoltage;
    next_st.uvS2 = st.uvS1;
    next_st.ocS1 = overcurrent;
    next_st.ocS2 = st.ocS1;
    next_st.regS1 = inRegulation;
    next_st.regS2 = st.regS1;
    allKeepOff = 1'b1;
    for (int i = 0; i < NUM_REG; i++) begin
      allKeepOff = allKeepOff & ~regCfg[i].sleepKeep;
    end
    // long-press timer restarts on release
    if (buttonStyleSelect && !st.btnS2) begin
      if (st.lpCnt <= LONG_PRESS_CYC) begin
        next_st.lpCnt = st.lpCnt + 1'b1; // RQ23
      end
    end else begin
      next_st.lpCnt = '0; // RQ23
    end
    longEvt = buttonStyleSelect && !st.btnS2 && longPressOffEnable &&
              st.lpCnt == LONG_PRESS_CYC; // RQ2
    offEvt = (!buttonStyleSelect && !st.btnS2) || longEvt; // RQ1
    turnOn = !st.thermS2 && !st.uvS2 &&
             (st.restart || (buttonStyleSelect ?
              (st.btnPrev && !st.btnS2) : st.btnS2)); // RQ4 RQ22
    standbyCtl = st.stbyS2 ^ standbyPolarityInvert; // RQ21
    case (st.state)
      ST_COIN: begin
        if (!st.uvS2) begin
          next_st.state = ST_OFF;
        end
      end
      ST_OFF, ST_SLEEP: begin
        if (turnOn) begin
          next_st.state = ST_ON;
          next_st.restart = 1'b0;
          next_st.seqRun = 1'b1; // RQ19
          next_st.seqCnt = '0;
        end
      end
      ST_ON, ST_STANDBY: begin
        if (offEvt) begin
          next_st.state = allKeepOff ? ST_OFF : ST_SLEEP; // RQ16
          next_st.seqRun = 1'b0;
          next_st.restart = longEvt && autoRestartEnable; // RQ3
          for (int i = 0; i < NUM_REG; i++) begin
            if (!regCfg[i].sleepKeep) begin
              next_st.regs[i].enable = 1'b0; // RQ16
            end
          end
        end else if (st.state == ST_ON && standbyCtl) begin
          next_st.state = ST_STANDBY; // RQ21
        end else if (st.state == ST_STANDBY && !standbyCtl) begin
          next_st.state = ST_ON; // RQ14
        end
      end
      default: next_st.state = ST_OFF;
    endcase
    // thermal shutdown: no interrupt, just off
    if (st.thermS2 && st.state != ST_COIN) begin
      next_st.state = ST_OFF; // RQ4 RQ5 RQ6
      next_st.seqRun = 1'b0;
      next_st.restart = 1'b0;
    end
    if (st.uvS2) begin
      next_st.state = ST_COIN; // RQ7
      next_st.seqRun = 1'b0;
      next_st.restart = 1'b0;
    end
    if (next_st.state == ST_OFF || next_st.state == ST_COIN) begin
      for (int i = 0; i < NUM_REG; i++) begin
        next_st.regs[i].enable = 1'b0;
      end
    end
    if (st.seqRun) begin
      next_st.seqCnt = st.seqCnt + 1'b1;
      if (st.seqCnt == slotAt(NUM_REG - 1)) begin
        next_st.seqRun = 1'b0;
      end
    end
    for (int i = 0; i < NUM_REG; i++) begin
      // start-up slot for regulators not already running
      if (st.seqRun && !st.regs[i].enable && st.seqCnt == slotAt(i) &&
          (next_st.state == ST_ON || next_st.state == ST_STANDBY)) begin
        next_st.regs[i].enable = 1'b1; // RQ19
        next_st.regs[i].phase = SS_PFM;
        next_st.regs[i].ssCnt = '0;
      end else if (st.regs[i].enable && next_st.regs[i].enable) begin
        case (st.regs[i].phase)
          SS_PFM, SS_APS: begin
            next_st.regs[i].ssCnt = st.regs[i].ssCnt + 1'b1;
            if (st.regs[i].ssCnt == SS_STEP_CYC) begin
              next_st.regs[i].ssCnt = '0;
              next_st.regs[i].phase =
                (st.regs[i].phase == SS_PFM) ? SS_APS : SS_PWM; // RQ9
            end
          end
          SS_PWM: begin
            if (!st.regS2[i]) begin
              next_st.regs[i].ssCnt = '0;
            end else if (st.regs[i].ssCnt == SETTLE_CYC) begin
              next_st.regs[i].phase = SS_DONE; // RQ9
            end else begin
              next_st.regs[i].ssCnt = st.regs[i].ssCnt + 1'b1;
            end
          end
          default: next_st.regs[i].phase = SS_DONE;
        endcase
      end
      // overcurrent persistence
      next_st.fault[i] = 1'b0;
      if (st.regs[i].enable && st.ocS2[i]) begin
        if (st.regs[i].ocCnt <= OC_FAULT_CYC) begin
          next_st.regs[i].ocCnt = st.regs[i].ocCnt + 1'b1;
        end
        next_st.fault[i] = st.regs[i].ocCnt == OC_FAULT_CYC; // RQ8
      end else begin
        next_st.regs[i].ocCnt = '0; // RQ23
      end
      // output selection from the next state
      next_st.outs[i].setpoint = regCfg[i].normalSetpoint;
      if (!next_st.regs[i].enable) begin
        next_st.outs[i].mode = MODE_OFF;
      end else if (next_st.state == ST_SLEEP) begin
        next_st.outs[i].mode = MODE_PFM; // RQ17
        next_st.outs[i].setpoint = (i == 0) ?
          {1'b0, group1SleepSetpoint} :
          otherSleepSetpoint[(i == 0) ? 0 : i - 1]; // RQ20
      end else if (next_st.regs[i].phase == SS_PFM) begin
        next_st.outs[i].mode = MODE_PFM; // RQ9
      end else if (next_st.regs[i].phase == SS_APS) begin
        next_st.outs[i].mode = MODE_APS; // RQ9
      end else if (next_st.regs[i].phase == SS_PWM) begin
        next_st.outs[i].mode = MODE_PWM; // RQ9
      end else if (next_st.state == ST_STANDBY) begin
        next_st.outs[i].mode =
          decodeMode(regCfg[i].switchModeSelect, 1'b1); // RQ13 RQ12
        next_st.outs[i].setpoint = regCfg[i].standbySetpoint; // RQ13 RQ15
      end else begin
        next_st.outs[i].mode =
          decodeMode(regCfg[i].switchModeSelect, 1'b0); // RQ14 RQ18
      end
      next_st.outs[i].enable = next_st.outs[i].mode != MODE_OFF; // RQ11
      next_st.outs[i].discharge = next_st.outs[i].mode == MODE_OFF; // RQ11
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign regOut = st.outs;
  assign faultIrq = st.fault;
  assign powerState = st.state;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_uv_seen;
    st.uvS2;
  endsequence

  property p_coin_entry;
    @(posedge ref_clk) disable iff (!reset_n)
      s_uv_seen |=> powerState == ST_COIN;
  endproperty
  a_coin_entry: assert property (p_coin_entry) // RQ7
    else $error("undervoltage did not enter coin cell");

  property p_thermal_off;
    @(posedge ref_clk) disable iff (!reset_n)
      st.thermS2 && !st.uvS2 |=> powerState == ST_OFF && !regOut[0].enable;
  endproperty
  a_thermal_off: assert property (p_thermal_off) // RQ4
    else $error("thermal condition did not hold off");

  property p_short_off;
    @(posedge ref_clk) disable iff (!reset_n)
      powerState == ST_ON && !buttonStyleSelect && !st.btnS2 &&
      allKeepOff && !st.thermS2 && !st.uvS2 |=> powerState == ST_OFF;
  endproperty
  a_short_off: assert property (p_short_off) // RQ1
    else $error("button low did not power off");

  property p_long_press;
    @(posedge ref_clk) disable iff (!reset_n)
      powerState == ST_ON && longEvt && allKeepOff && !st.thermS2 &&
      !st.uvS2 |=> powerState == ST_OFF && st.restart == $past(
      autoRestartEnable);
  endproperty
  a_long_press: assert property (p_long_press) // RQ2
    else $error("long press did not power off");

  property p_no_early_long;
    @(posedge ref_clk) disable iff (!reset_n)
      longEvt |-> !$past(st.btnS2) && $past(st.lpCnt) == LONG_PRESS_CYC - 1;
  endproperty
  a_no_early_long: assert property (p_no_early_long) // RQ23
    else $error("long press fired early");

  property p_sleep_pfm;
    @(posedge ref_clk) disable iff (!reset_n)
      powerState == ST_SLEEP && regOut[0].enable |->
      regOut[0].mode == MODE_PFM &&
      regOut[0].setpoint == {1'b0, $past(group1SleepSetpoint)};
  endproperty
  a_sleep_pfm: assert property (p_sleep_pfm) // RQ17
    else $error("sleep output not at sleep set point");

  property p_off_discharge;
    @(posedge ref_clk) disable iff (!reset_n)
      $past(reset_n) && regOut[0].mode == MODE_OFF |-> !regOut[0].enable &&
      regOut[0].discharge;
  endproperty
  a_off_discharge: assert property (p_off_discharge) // RQ11
    else $error("off mode output not discharged");

  property p_fault_after_persist;
    @(posedge ref_clk) disable iff (!reset_n)
      faultIrq[0] |-> $past(st.regs[0].ocCnt) == OC_FAULT_CYC ##1 !faultIrq[0];
  endproperty
  a_fault_after_persist: assert property (p_fault_after_persist) // RQ8
    else $error("fault raised without persistence");

  property p_standby_entry;
    @(posedge ref_clk) disable iff (!reset_n)
      powerState == ST_ON && standbyCtl && !offEvt && !st.thermS2 &&
      !st.uvS2 |=> powerState == ST_STANDBY;
  endproperty
  a_standby_entry: assert property (p_standby_entry) // RQ21
    else $error("standby control not followed");

endmodule : regulator_power_state_control
`default_nettype wire

//--- dv/processor_model.sv
// system processor side: drives the button and standby pins
`timescale 1ns/1ps
`default_nettype none

module processor_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pressReq,
  input wire logic standbyReq,
  output logic powerButtonInput,
  output logic standbyPin
);

  // pins move only just after a clock edge or on the asynchronous reset, held until the next request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      powerButtonInput <= 1'b0;
      standbyPin <= 1'b0;
    end else begin
      powerButtonInput <= pressReq;
      standbyPin <= standbyReq;
    end
  end

endmodule : processor_model

`default_nettype wire

//--- dv/regulator_power_state_control_tb.sv
// self-checking bench for the regulator power state control
`timescale 1ns/1ps
`default_nettype none

module regulator_power_state_control_tb;
  import power_state_pkg::*;

  logic ref_clk, reset_n, pressReq, standbyReq, btn, stbyPin;
  logic thermal, uv, style, lpEn, arEn, inv, sawOff;
  logic [3:0] oc, inReg, fault;
  reg_cfg_t [3:0] cfg;
  logic [5:0] g1Sleep;
  logic [2:0][6:0] otherSleep;
  reg_out_t [3:0] out;
  power_state_t state;
  logic [7:0] fc [4];
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8,
    4'hC, 4'hD};
  switch_mode_t ssSeq [3] = '{MODE_PFM, MODE_APS, MODE_PWM};
  int nFail, totalChecks, seed, k;

  regulator_power_state_control #(.LONG_PRESS_CYC(27'h28),
    .OC_FAULT_CYC(27'h14), .SETTLE_CYC(27'hA), .SEQ_SLOT_CYC(27'h4),
    .SS_STEP_CYC(27'h3)) regulator_power_state_control_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .powerButtonInput(btn),
    .standbyPin(stbyPin), .thermalShutdown(thermal),
    .inputUndervoltage(uv), .overcurrent(oc), .inRegulation(inReg),
    .buttonStyleSelect(style), .longPressOffEnable(lpEn),
    .autoRestartEnable(arEn), .standbyPolarityInvert(inv),
    .regCfg(cfg), .group1SleepSetpoint(g1Sleep),
    .otherSleepSetpoint(otherSleep), .regOut(out), .faultIrq(fault),
    .powerState(state));

  processor_model processor_model_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .pressReq(pressReq), .standbyReq(standbyReq),
    .powerButtonInput(btn), .standbyPin(stbyPin));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!reset_n) fc[i] <= 8'h0;
      else if (fault[i] === 1'b1) fc[i] <= fc[i] + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic switch_mode_t decN(input logic [3:0] c);
    case (c)
      SEL_PWM_OFF, SEL_PWM_PWM, SEL_PWM_APS, SEL_PWM_PFM: return MODE_PWM;
      SEL_PFM_OFF: return MODE_PFM;
      SEL_APS_OFF, SEL_APS_APS, SEL_APS_PFM: return MODE_APS;
      default: return MODE_OFF;
    endcase
  endfunction : decN

  function automatic switch_mode_t decS(input logic [3:0] c);
    case (c)
      SEL_PWM_PWM: return MODE_PWM;
      SEL_PWM_APS, SEL_APS_APS: return MODE_APS;
      SEL_APS_PFM, SEL_PWM_PFM: return MODE_PFM;
      default: return MODE_OFF;
    endcase
  endfunction : decS

  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic waitState(input power_state_t s, input int maxc);
    int j = 0;
    while (state !== s && j < maxc) begin
      tick(1);
      j++;
    end
    check("powerState", 16'(state), 16'(s));
  endtask : waitState

  // off outputs carry no meaningful set point
  task automatic waitOut(input int i, input switch_mode_t m,
    input logic [6:0] sp, input int maxc);
    int j = 0;
    logic off = (m == MODE_OFF);
    while (!(out[i].mode === m && (off || out[i].setpoint === sp))
      && j < maxc) begin
      tick(1);
      j++;
    end
    check("regOut.mode", 16'(out[i].mode), 16'(m));
    check("regOut.enable", 16'(out[i].enable), 16'(!off));
    check("regOut.discharge", 16'(out[i].discharge), 16'(off));
    if (!off) check("regOut.setpoint", 16'(out[i].setpoint), 16'(sp));
  endtask : waitOut

  task automatic newCfg();
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      cfg[i].switchModeSelect <= codes[1 + $unsigned($random(seed)) % 8];
      cfg[i].normalSetpoint <= 7'($random(seed));
      cfg[i].standbySetpoint <= 7'($random(seed));
    end
    tick(1);
  endtask : newCfg

  task automatic finalReport();
    if (nFail == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finalReport

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    nFail++;
    finalReport();
  end

  initial begin
    seed = 32'hE5C56B68;
    nFail = 0;
    totalChecks = 0;
    {reset_n, pressReq, standbyReq, thermal, uv, style} = 6'h00;
    {lpEn, arEn, inv, sawOff} = 4'h0;
    oc = 4'h0;
    inReg = 4'hF;
    cfg = '0;
    g1Sleep = 6'($random(seed));
    otherSleep = 21'($random(seed));
    repeat (10) @(posedge ref_clk);
    check("resetState", 16'(state), 16'(ST_OFF));
    check("resetOut", 16'(out[0]), 16'h0);
    reset_n <= 1'b1;
    newCfg();
    @(posedge ref_clk);
    pressReq <= 1'b1;
    waitState(ST_ON, 20);
    for (int s = 0; s < 3; s++) begin
      k = 0;
      while (out[0].mode !== ssSeq[s] && k < 60) begin
        tick(1);
        k++;
      end
      check("softStart", 16'(out[0].mode), 16'(ssSeq[s]));
    end
    for (int i = 0; i < 4; i++)
      waitOut(i, decN(cfg[i].switchModeSelect), cfg[i].normalSetpoint,
        200);
    for (int c = 0; c < 16; c++) begin
      @(posedge ref_clk);
      cfg[1].switchModeSelect <= 4'(c);
      tick(1);
      waitOut(1, decN(4'(c)), cfg[1].normalSetpoint, 200);
    end
    newCfg();
    for (int i = 0; i < 4; i++)
      waitOut(i, decN(cfg[i].switchModeSelect), cfg[i].normalSetpoint,
        200);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      inv <= 1'(v);
      standbyReq <= !1'(v);
      waitState(ST_STANDBY, 20);
      for (int i = 0; i < 4; i++)
        waitOut(i, decS(cfg[i].switchModeSelect), cfg[i].standbySetpoint,
          20);
      @(posedge ref_clk);
      standbyReq <= 1'(v);
      waitState(ST_ON, 20);
      for (int i = 0; i < 4; i++)
        waitOut(i, decN(cfg[i].switchModeSelect), cfg[i].normalSetpoint,
          200);
    end
    @(posedge ref_clk);
    cfg[2].switchModeSelect <= SEL_PWM_PWM;
    tick(1);
    waitOut(2, MODE_PWM, cfg[2].normalSetpoint, 200);
    for (int b = 0; b < 2; b++) begin
      @(posedge ref_clk);
      oc[0] <= 1'b1;
      repeat (15) @(posedge ref_clk);
      oc[0] <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    tick(8);
    check("faultShort", 16'(fc[0]), 16'h0);
    @(posedge ref_clk);
    oc[0] <= 1'b1;
    repeat (40) @(posedge ref_clk);
    oc[0] <= 1'b0;
    tick(8);
    check("faultLong", 16'(fc[0]), 16'h1);
    @(posedge ref_clk);
    cfg[0].sleepKeep <= 1'b1;
    cfg[1].sleepKeep <= 1'b1;
    pressReq <= 1'b0;
    waitState(ST_SLEEP, 20);
    waitOut(0, MODE_PFM, {1'b0, g1Sleep}, 20);
    waitOut(1, MODE_PFM, otherSleep[0], 20);
    waitOut(2, MODE_OFF, 7'h0, 20);
    waitOut(3, MODE_OFF, 7'h0, 20);
    @(posedge ref_clk);
    pressReq <= 1'b1;
    waitState(ST_ON, 20);
    check("keptOn", 16'(out[1].enable), 16'h1);
    check("resequenced", 16'(out[2].enable), 16'h0);
    waitOut(1, decN(cfg[1].switchModeSelect), cfg[1].normalSetpoint,
      3);
    waitOut(2, MODE_PWM, cfg[2].normalSetpoint, 200);
    @(posedge ref_clk);
    cfg[0].sleepKeep <= 1'b0;
    cfg[1].sleepKeep <= 1'b0;
    thermal <= 1'b1;
    waitState(ST_OFF, 20);
    tick(30);
    check("thermalHold", 16'(state), 16'(ST_OFF));
    check("thermalIrq", 16'(fc[1] + fc[2] + fc[3]), 16'h0);
    @(posedge ref_clk);
    thermal <= 1'b0;
    waitState(ST_ON, 20);
    @(posedge ref_clk);
    uv <= 1'b1;
    waitState(ST_COIN, 20);
    @(posedge ref_clk);
    uv <= 1'b0;
    waitState(ST_ON, 40);
    @(posedge ref_clk);
    style <= 1'b1;
    lpEn <= 1'b1;
    pressReq <= 1'b0;
    repeat (20) @(posedge ref_clk);
    pressReq <= 1'b1;
    tick(20);
    check("shortPress", 16'(state), 16'(ST_ON));
    @(posedge ref_clk);
    pressReq <= 1'b0;
    waitState(ST_OFF, 80);
    @(posedge ref_clk);
    pressReq <= 1'b1;
    tick(10);
    check("offHold", 16'(state), 16'(ST_OFF));
    @(posedge ref_clk);
    pressReq <= 1'b0;
    waitState(ST_ON, 20);
    @(posedge ref_clk);
    pressReq <= 1'b1;
    arEn <= 1'b1;
    tick(6);
    sawOff = 1'b0;
    @(posedge ref_clk);
    pressReq <= 1'b0;
    repeat (70) begin
      tick(1);
      if (state === ST_OFF) sawOff = 1'b1;
    end
    check("restartOff", 16'(sawOff), 16'h1);
    check("restartOn", 16'(state), 16'(ST_ON));
    finalReport();
  end

endmodule : regulator_power_state_control_tb

`default_nettype wire
